// ==== rtl/loop_cmd_ctrl.sv ====
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
module loop_cmd_ctrl
  import loop_cmd_pkg::*;
(
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // wishbone classic slave
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [loop_cmd_pkg::WB_ADR_W-1:0]  adr_i,
  input  wire logic [3:0]                    sel_i,
  input  wire logic [31:0]                   dat_i,
  output logic      [31:0]                   dat_o,
  output logic                               ack_o,
  // interrupt
  output logic                               irq_o,
  // t2 framers and formatters
  input  wire loop_cmd_pkg::c_obs_s          rx_obs_i,
  input  wire logic [loop_cmd_pkg::NUM_PORTS-1:0] tx_c12_i,
  output logic      [loop_cmd_pkg::NUM_PORTS-1:0] tx_c3_o,
  // tributary pins
  input  wire loop_cmd_pkg::trib_s           rx_trib_i,
  input  wire loop_cmd_pkg::trib_s           tx_trib_i,
  output loop_cmd_pkg::trib_s                tx_trib_o,
  // drop ports
  output logic                               drop_a_clock_out_o,
  output logic                               drop_a_data_out_o,
  output logic                               drop_b_clock_out_o,
  output logic                               drop_b_data_out_o,
  // insert ports
  input  wire logic                          insert_a_clock_in_i,
  input  wire logic                          insert_a_data_in_i,
  input  wire logic                          insert_b_clock_in_i,
  input  wire logic                          insert_b_data_in_i
);
  import loop_cmd_pkg::*;

  localparam int SYNC_W = 4 * NUM_PORTS + 4;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [NUM_PORTS-1:0] far_end_loop_cmd_ff;
  logic [SEL_W-1:0]     drop_a_select_ff;
  logic [SEL_W-1:0]     drop_b_select_ff;
  logic [SEL_W-1:0]     insert_a_select_ff;
  logic [SEL_W-1:0]     insert_b_select_ff;
  logic                 irq_stat_ff;
  logic                 loop_cmd_irq_mask_ff;
  logic                 irq_ff;
  logic                 ack_ff;
  logic [31:0]          rdat_ff;
  logic [NUM_PORTS-1:0] det_prev_ff;
  logic [NUM_PORTS-1:0] tx_c3_ff;
  trib_s                tx_trib_ff;
  logic                 drop_a_clk_ff;
  logic                 drop_a_dat_ff;
  logic                 drop_b_clk_ff;
  logic                 drop_b_dat_ff;

  logic [NUM_PORTS-1:0] loop_cmd_detected;
  logic [SYNC_W-1:0]    sync_q;
  trib_s                rx_q;
  trib_s                tx_q;
  logic                 ins_a_clk_q;
  logic                 ins_a_dat_q;
  logic                 ins_b_clk_q;
  logic                 ins_b_dat_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and c3 detectors

  pin_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i ({rx_trib_i, tx_trib_i, insert_a_clock_in_i, insert_a_data_in_i,
             insert_b_clock_in_i, insert_b_data_in_i}),
    .q_o   (sync_q)
  );

  assign {rx_q, tx_q, ins_a_clk_q, ins_a_dat_q, ins_b_clk_q, ins_b_dat_q} = sync_q;

  loop_cmd_detect #(
    .N    (NUM_PORTS),
    .CONF (CONFIRM_FRAMES)
  ) u_detect (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .obs_i      (rx_obs_i),
    .detected_o (loop_cmd_detected)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire [IDX_W-1:0] idx     = adr_i[WB_ADR_W-1:2];
  wire             req     = cyc_i && stb_i;
  wire             wr_take = req && we_i && ack_ff;  // write lands on the edge the master sees ack
  wire             rd_new  = req && !ack_ff;
  wire             wr_lo   = wr_take && sel_i[0];
  wire             wr_hi   = wr_take && sel_i[1];

  wire hit_cmd_lo  = (idx == IDX_CMD_LO);
  wire hit_cmd_hi  = (idx == IDX_CMD_HI);
  wire hit_stat_lo = (idx == IDX_STAT_LO);
  wire hit_stat_hi = (idx == IDX_STAT_HI);
  wire hit_drop    = (idx == IDX_DROP_SEL);
  wire hit_ins     = (idx == IDX_INS_SEL);
  wire hit_istat   = (idx == IDX_IRQ_STAT);
  wire hit_imask   = (idx == IDX_IRQ_MASK);

  // status words are read live from the detectors, nothing latched
  wire [15:0] stat_lo = loop_cmd_detected[LO_PORTS-1:0];
  wire [15:0] stat_hi = {4'h0, loop_cmd_detected[NUM_PORTS-1:LO_PORTS]};
  wire [15:0] sel_pair_drop = {3'h0, drop_b_select_ff, 3'h0, drop_a_select_ff};
  wire [15:0] sel_pair_ins  = {3'h0, insert_b_select_ff, 3'h0, insert_a_select_ff};

  // unmapped indices answer with zero
  wire [15:0] rd_word =
    hit_cmd_lo  ? far_end_loop_cmd_ff[LO_PORTS-1:0] :
    hit_cmd_hi  ? {4'h0, far_end_loop_cmd_ff[NUM_PORTS-1:LO_PORTS]} :
    hit_stat_lo ? stat_lo :
    hit_stat_hi ? stat_hi :
    hit_drop    ? sel_pair_drop :
    hit_ins     ? sel_pair_ins :
    hit_istat   ? {15'h0000, irq_stat_ff} :
    hit_imask   ? {15'h0000, loop_cmd_irq_mask_ff} :
    16'h0000;

  // ack for one cycle; read data is captured with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      ack_ff  <= rd_new;
      rdat_ff <= rd_new ? {16'h0000, rd_word} : rdat_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  // each byte lane enables only its own bits; lane one of the high word holds four ports
  wire [NUM_PORTS-1:0] cmd_en    = {{4{wr_hi && hit_cmd_hi}}, {8{wr_lo && hit_cmd_hi}},
                                    {8{wr_hi && hit_cmd_lo}}, {8{wr_lo && hit_cmd_lo}}};
  wire [NUM_PORTS-1:0] cmd_wdata = (wr_take && hit_cmd_hi) ? {dat_i[HI_PORTS-1:0], 16'h0000}
                                                           : {12'h000, dat_i[15:0]};

  // command words, both halves share one vector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      far_end_loop_cmd_ff <= CMD_RST;
    end else begin
      far_end_loop_cmd_ff <= (far_end_loop_cmd_ff & ~cmd_en) | (cmd_wdata & cmd_en);
    end
  end

  // selectors live in the low five bits of each byte lane
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drop_a_select_ff   <= SEL_RST;
      drop_b_select_ff   <= SEL_RST;
      insert_a_select_ff <= SEL_RST;
      insert_b_select_ff <= SEL_RST;
    end else begin
      if (wr_lo && hit_drop) drop_a_select_ff   <= dat_i[SEL_A_LSB +: SEL_W];
      if (wr_hi && hit_drop) drop_b_select_ff   <= dat_i[SEL_B_LSB +: SEL_W];
      if (wr_lo && hit_ins)  insert_a_select_ff <= dat_i[SEL_A_LSB +: SEL_W];
      if (wr_hi && hit_ins)  insert_b_select_ff <= dat_i[SEL_B_LSB +: SEL_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: sticky on any detection rising, write one to clear

  wire any_rise  = |(loop_cmd_detected & ~det_prev_ff);
  wire irq_clear = wr_lo && hit_istat && dat_i[IRQ_LOOP_BIT];

  // a rise in the clearing cycle wins so the event is never lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_prev_ff          <= '0;
      irq_stat_ff          <= 1'b0;
      loop_cmd_irq_mask_ff <= MASK_RST;
      irq_ff               <= 1'b0;
    end else begin
      det_prev_ff          <= loop_cmd_detected;
      irq_stat_ff          <= any_rise | (irq_stat_ff & ~irq_clear);
      if (wr_lo && hit_imask) loop_cmd_irq_mask_ff <= dat_i[IRQ_LOOP_BIT];
      irq_ff               <= irq_stat_ff & loop_cmd_irq_mask_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // c3 generation and drop/insert routing

  wire [NUM_PORTS-1:0] ins_a_hit = sel_onehot(insert_a_select_ff);
  wire [NUM_PORTS-1:0] ins_b_hit = sel_onehot(insert_b_select_ff);
  wire [NUM_PORTS-1:0] keep      = ~(ins_a_hit | ins_b_hit);
  wire [NUM_PORTS-1:0] nxt_tx_clk = (tx_q.clk & keep) | (ins_a_hit & {NUM_PORTS{ins_a_clk_q}})
                                  | (ins_b_hit & {NUM_PORTS{ins_b_clk_q}});
  wire [NUM_PORTS-1:0] nxt_tx_dat = (tx_q.data & keep) | (ins_a_hit & {NUM_PORTS{ins_a_dat_q}})
                                  | (ins_b_hit & {NUM_PORTS{ins_b_dat_q}});
  wire [NUM_PORTS-1:0] drop_a_hit = sel_onehot(drop_a_select_ff);
  wire [NUM_PORTS-1:0] drop_b_hit = sel_onehot(drop_b_select_ff);

  // an unselected drop port reduces to zero through the empty mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_c3_ff      <= '0;
      tx_trib_ff    <= '0;
      drop_a_clk_ff <= 1'b0;
      drop_a_dat_ff <= 1'b0;
      drop_b_clk_ff <= 1'b0;
      drop_b_dat_ff <= 1'b0;
    end else begin
      tx_c3_ff      <= tx_c12_i ^ far_end_loop_cmd_ff;
      tx_trib_ff    <= {nxt_tx_clk, nxt_tx_dat};
      drop_a_clk_ff <= |(rx_q.clk & drop_a_hit);
      drop_a_dat_ff <= |(rx_q.data & drop_a_hit);
      drop_b_clk_ff <= |(rx_q.clk & drop_b_hit);
      drop_b_dat_ff <= |(rx_q.data & drop_b_hit);
    end
  end

  assign dat_o              = rdat_ff;
  assign ack_o              = ack_ff;
  assign irq_o              = irq_ff;
  assign tx_c3_o            = tx_c3_ff;
  assign tx_trib_o          = tx_trib_ff;
  assign drop_a_clock_out_o = drop_a_clk_ff;
  assign drop_a_data_out_o  = drop_a_dat_ff;
  assign drop_b_clock_out_o = drop_b_clk_ff;
  assign drop_b_data_out_o  = drop_b_dat_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_cmd_held;
    far_end_loop_cmd_ff[NUM_PORTS-1] [*2];
  endsequence

  property p_c3_inverted;
    @(posedge clk_i) disable iff (rst_i)
      s_cmd_held |=> tx_c3_o[NUM_PORTS-1] == !$past(tx_c12_i[NUM_PORTS-1]);
  endproperty
  a_c3_inverted: assert property (p_c3_inverted)
    else $error("c3 not inverted while command held");

  property p_c3_plain;
    @(posedge clk_i) disable iff (rst_i)
      !far_end_loop_cmd_ff[0] |=> tx_c3_o[0] == $past(tx_c12_i[0]);
  endproperty
  a_c3_plain: assert property (p_c3_plain)
    else $error("c3 differs from c1 c2 with command low");

  property p_stat_live;
    @(posedge clk_i) disable iff (rst_i)
      rd_new && hit_stat_lo |=> dat_o[15:0] == $past(loop_cmd_detected[LO_PORTS-1:0]) && ack_o;
  endproperty
  a_stat_live: assert property (p_stat_live)
    else $error("low status word not the live detection state");

  property p_stat_hi_map;
    @(posedge clk_i) disable iff (rst_i)
      rd_new && hit_stat_hi |=> dat_o[31:12] == 20'h00000
        && dat_o[11:0] == $past(loop_cmd_detected[NUM_PORTS-1:LO_PORTS]);
  endproperty
  a_stat_hi_map: assert property (p_stat_hi_map)
    else $error("high status word mapping wrong");

  property p_irq_raise;
    @(posedge clk_i) disable iff (rst_i)
      any_rise && loop_cmd_irq_mask_ff && !(wr_lo && hit_imask) |-> ##2 irq_o;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("unmasked detection did not raise interrupt");

  property p_irq_masked;
    @(posedge clk_i) disable iff (rst_i)
      irq_o |-> $past(loop_cmd_irq_mask_ff) && $past(irq_stat_ff);
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt without masked-in status");

  property p_drop_off;
    @(posedge clk_i) disable iff (rst_i)
      !sel_valid(drop_a_select_ff) |=> !drop_a_clock_out_o && !drop_a_data_out_o;
  endproperty
  a_drop_off: assert property (p_drop_off)
    else $error("drop port a not low with no port selected");

  property p_drop_route;
    @(posedge clk_i) disable iff (rst_i)
      drop_b_select_ff == SEL_LAST |=> drop_b_data_out_o == $past(rx_q.data[NUM_PORTS-1]);
  endproperty
  a_drop_route: assert property (p_drop_route)
    else $error("drop port b not routing selected tributary");

  property p_ins_route;
    @(posedge clk_i) disable iff (rst_i)
      insert_a_select_ff == SEL_FIRST |=> tx_trib_o.clk[0] == $past(ins_a_clk_q);
  endproperty
  a_ins_route: assert property (p_ins_route)
    else $error("insert port a not replacing port 1 clock");

  property p_ins_ignore;
    @(posedge clk_i) disable iff (rst_i)
      !sel_valid(insert_a_select_ff) && !sel_valid(insert_b_select_ff) |=>
        tx_trib_o == $past(tx_q);
  endproperty
  a_ins_ignore: assert property (p_ins_ignore)
    else $error("insert pins affected output with no port selected");

  property p_reset_clear;
    @(posedge clk_i) rst_i |=>
      far_end_loop_cmd_ff == CMD_RST && drop_a_select_ff == SEL_RST && insert_b_select_ff == SEL_RST;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset left command or selector state");

endmodule : loop_cmd_ctrl

// ==== rtl/loop_cmd_detect.sv ====
`timescale 1ns/1ps
module loop_cmd_detect
  import loop_cmd_pkg::*;
#(
  parameter int N    = loop_cmd_pkg::NUM_PORTS,
  parameter int CONF = loop_cmd_pkg::CONFIRM_FRAMES
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // framer observations and detection state
  input  wire loop_cmd_pkg::c_obs_s obs_i,
  output logic [N-1:0]              detected_o
);
  import loop_cmd_pkg::*;

  typedef enum logic [1:0] {IDLE_S = 2'b01, LOOP_S = 2'b10} det_state_e;

  det_state_e         state_ff [N];
  logic [CNT_W-1:0]   cnt_ff   [N];
  logic [N-1:0]       in_loop;
  logic [N-1:0]       inv;
  logic [N-1:0]       differ;

  // c3 counts as inverted only when it opposes both c1 and c2
  assign inv    = (obs_i.c3 & ~obs_i.c1 & ~obs_i.c2) | (~obs_i.c3 & obs_i.c1 & obs_i.c2);
  assign differ = obs_i.frame & (inv ^ in_loop);

  function automatic det_state_e flip(input det_state_e s);
    case (s)
      IDLE_S:  return LOOP_S;
      LOOP_S:  return IDLE_S;
      default: return IDLE_S;
    endcase
  endfunction : flip

  // per-port run counter; a frame that agrees with the state restarts it
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < N; i++) begin
      if (rst_i) begin
        state_ff[i] <= IDLE_S;
        cnt_ff[i]   <= '0;
      end else if (obs_i.frame[i]) begin
        if (!differ[i]) begin
          cnt_ff[i] <= '0;
        end else if (cnt_ff[i] == CNT_W'(CONF - 1)) begin
          state_ff[i] <= flip(state_ff[i]);
          cnt_ff[i]   <= '0;
        end else begin
          cnt_ff[i] <= cnt_ff[i] + 1'b1;
        end
      end
    end
  end

  for (genvar g = 0; g < N; g++) begin : g_port
    assign in_loop[g] = (state_ff[g] == LOOP_S);

    // detection may only change on the fifth frame of a run
    property p_change_after_five;
      @(posedge clk_i) disable iff (rst_i)
        (in_loop[g] != $past(in_loop[g])) |->
          ($past(cnt_ff[g]) == CNT_W'(CONF - 1)) && $past(differ[g]);
    endproperty
    a_change_after_five: assert property (p_change_after_five)
      else $error("detection changed without five consecutive frames");
  end

  assign detected_o = in_loop;

endmodule : loop_cmd_detect

// ==== rtl/loop_cmd_pkg.sv ====
package loop_cmd_pkg;

  // tributary count and selector geometry
  localparam int NUM_PORTS      = 28;
  localparam int LO_PORTS       = 16;
  localparam int HI_PORTS       = 12;
  localparam int SEL_W          = 5;
  localparam int SEL_A_LSB      = 0;
  localparam int SEL_B_LSB      = 8;
  localparam int CONFIRM_FRAMES = 5;
  localparam int CNT_W          = 3;

  // wishbone geometry: register index sits in adr[9:2]
  localparam int WB_ADR_W = 10;
  localparam int IDX_W    = 8;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CMD_LO   = 8'h58;
  localparam logic [IDX_W-1:0] IDX_CMD_HI   = 8'h5a;
  localparam logic [IDX_W-1:0] IDX_STAT_LO  = 8'h5c;
  localparam logic [IDX_W-1:0] IDX_STAT_HI  = 8'h5e;
  localparam logic [IDX_W-1:0] IDX_DROP_SEL = 8'h60;
  localparam logic [IDX_W-1:0] IDX_INS_SEL  = 8'h62;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'h64;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h66;

  // interrupt bit position and reset values
  localparam int                 IRQ_LOOP_BIT = 0;
  localparam logic [NUM_PORTS-1:0] CMD_RST    = 28'h0000000;
  localparam logic [SEL_W-1:0]   SEL_RST      = 5'h00;
  localparam logic               MASK_RST     = 1'b0;

  // selector codes: 1..28 pick a port, everything else picks none
  localparam logic [SEL_W-1:0] SEL_FIRST = 5'h01;
  localparam logic [SEL_W-1:0] SEL_LAST  = 5'h1c;

  // per-port c-bit observations from the t2 framers
  typedef struct packed {
    logic [NUM_PORTS-1:0] frame;
    logic [NUM_PORTS-1:0] c1;
    logic [NUM_PORTS-1:0] c2;
    logic [NUM_PORTS-1:0] c3;
  } c_obs_s;

  // clock and data of all tributaries in one direction
  typedef struct packed {
    logic [NUM_PORTS-1:0] clk;
    logic [NUM_PORTS-1:0] data;
  } trib_s;

  function automatic logic sel_valid(input logic [SEL_W-1:0] code);
    return (code >= SEL_FIRST) && (code <= SEL_LAST);
  endfunction : sel_valid

  // one-hot port mask for a selector code, all zero for no port
  function automatic logic [NUM_PORTS-1:0] sel_onehot(input logic [SEL_W-1:0] code);
    logic [NUM_PORTS-1:0] r;
    r = '0;
    if (sel_valid(code)) r[code - SEL_FIRST] = 1'b1;
    return r;
  endfunction : sel_onehot

endpackage : loop_cmd_pkg

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // asynchronous pins and their filtered copy
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;

  // three stages; a change is taken only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff  <= '0;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= (s2_ff & s3_ff) | (q_ff & (s2_ff ^ s3_ff));
    end
  end

  assign q_o = q_ff;

endmodule : pin_sync

// ==== test/far_framer_model.sv ====
`timescale 1ns/1ps
module far_framer_model
  import loop_cmd_pkg::*;
(
  // clock
  input  wire logic           clk_i,
  // c-bit observations handed to the detectors
  output loop_cmd_pkg::c_obs_s obs_o
);
  initial obs_o = '0;
  ////////////////////////////////////////////////////////////////////////
  // one frame every other cycle; off-frame c3 flips so stale bits never look valid
  task automatic send(input int p, input logic inv, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      obs_o.frame[p] <= 1'b1;
      obs_o.c1[p]    <= k[0];
      obs_o.c2[p]    <= k[0];
      obs_o.c3[p]    <= k[0] ^ inv;
      @(posedge clk_i);
      obs_o.frame[p] <= 1'b0;
      obs_o.c3[p]    <= ~obs_o.c3[p];
    end
  endtask : send
endmodule : far_framer_model

// ==== test/t2_loopback_cmd_drop_insert_tb.sv ====
`timescale 1ns/1ps
module t2_loopback_cmd_drop_insert_tb;
  import loop_cmd_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, lclk = 0, ack, irq, p;
  logic        dac, dad, dbc, dbd, iac = 0, iad = 0, ibc = 0, ibd = 0;
  logic [9:0]  adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] dat = '0, rdat;
  logic [27:0] c12 = '0, c3;
  logic [15:0] q;
  c_obs_s      obs;
  trib_s       rx, tx_in = '0, tx_out;
  int          n_fail = 0, num_checks = 0, cnt;
  // drop rows: selector code, expected clock, expected data
  logic [6:0]  rows [8] = '{{5'h01, 2'b01}, {5'h03, 2'b01}, {5'h1c, 2'b01}, {5'h1b, 2'b00},
                            {5'h00, 2'b00}, {5'h1d, 2'b00}, {5'h1e, 2'b00}, {5'h1f, 2'b00}};
  logic [7:0]  ridx [5] = '{IDX_STAT_LO, IDX_STAT_HI, IDX_DROP_SEL, IDX_INS_SEL, 8'h70};

  // system clock and a free link clock on receive port 2, its edges falling on system clock falling edges
  always #5 clk_i = ~clk_i;
  always #80 lclk = ~lclk;
  assign rx = {26'h0, lclk, 1'b0, 28'h8000005};  // clock field first, then data

  loop_cmd_ctrl u_loop_cmd_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .irq_o(irq), .rx_obs_i(obs),
    .tx_c12_i(c12), .tx_c3_o(c3), .rx_trib_i(rx), .tx_trib_i(tx_in), .tx_trib_o(tx_out),
    .drop_a_clock_out_o(dac), .drop_a_data_out_o(dad), .drop_b_clock_out_o(dbc),
    .drop_b_data_out_o(dbd), .insert_a_clock_in_i(iac), .insert_a_data_in_i(iad),
    .insert_b_clock_in_i(ibc), .insert_b_data_in_i(ibd));
  far_framer_model u_far_framer_model (.clk_i(clk_i), .obs_o(obs));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // classic single cycle; no latency assumed, only a bounded wait
  task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d, output logic [15:0] r);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    dat <= {16'h0, d};
    sel <= 4'h3;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_fail++;
      report_and_stop();
    end
    r = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // watchdog, far beyond the several hundred cycles the sequence needs
  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ridx[i]) begin
      wb(0, ridx[i], 16'h0, q);
      chk(q, 0);
    end
    wb(1, IDX_STAT_HI, 16'hffff, q);
    wb(0, IDX_STAT_HI, 16'h0, q);
    chk(q, 0);
    // command words invert c3 per port
    c12 <= 28'h5a5a5a5;
    wb(1, IDX_CMD_LO, 16'hffff, q);
    wb(1, IDX_CMD_HI, 16'h0801, q);
    repeat (2) @(posedge clk_i);
    chk(c3, 28'h5a5a5a5 ^ 28'h801ffff);
    wb(1, IDX_CMD_LO, 16'h0, q); // host keeps commands at zero
    wb(1, IDX_CMD_HI, 16'h0, q);
    repeat (2) @(posedge clk_i);
    chk(c3, 28'h5a5a5a5);
    // detection on port 28: four, a break, four more, then the fifth
    u_far_framer_model.send(27, 1, 4);
    wb(0, IDX_STAT_HI, 16'h0, q);
    chk(q, 0);
    u_far_framer_model.send(27, 0, 1);
    u_far_framer_model.send(27, 1, 4);
    wb(0, IDX_STAT_HI, 16'h0, q);
    chk(q, 0);
    u_far_framer_model.send(27, 1, 1);
    wb(0, IDX_STAT_HI, 16'h0, q);
    chk(q, 16'h0800);
    wb(0, IDX_IRQ_STAT, 16'h0, q);
    chk({q[0], irq}, 2'b10);
    wb(1, IDX_IRQ_MASK, 16'h1, q);
    repeat (2) @(posedge clk_i);
    chk(irq, 1);
    u_far_framer_model.send(27, 0, 4);
    wb(0, IDX_STAT_HI, 16'h0, q);
    chk(q, 16'h0800);
    u_far_framer_model.send(27, 0, 1);
    wb(0, IDX_STAT_HI, 16'h0, q);
    chk(q, 0);
    u_far_framer_model.send(0, 1, 5);
    wb(0, IDX_STAT_LO, 16'h0, q); // host reads status only in t3 modes
    chk(q, 16'h0001);
    wb(1, IDX_IRQ_STAT, 16'h1, q);
    repeat (3) @(posedge clk_i);
    chk(irq, 0);
    // drop selector table, both ports on the same code
    foreach (rows[i]) begin
      wb(1, IDX_DROP_SEL, {3'h0, rows[i][6:2], 3'h0, rows[i][6:2]}, q);
      repeat (8) @(posedge clk_i);
      chk({dac, dad, dbc, dbd}, {rows[i][1:0], rows[i][1:0]});
    end
    // link clock through drop A: 400 cycles hold 25 link periods
    wb(1, IDX_DROP_SEL, 16'h0202, q);
    repeat (8) @(posedge clk_i);
    cnt = 0;
    p = dac;
    repeat (400) begin
      @(posedge clk_i);
      cnt += (dac === 1'b1 && p === 1'b0);
      p = dac;
    end
    chk(cnt inside {[24:26]}, 1);
    // insert A on port 1, B on port 28, then A parked and B off
    tx_in.data <= 28'h0000100;
    iac <= 1'b1;
    iad <= 1'b1;
    ibd <= 1'b1;
    wb(1, IDX_INS_SEL, 16'h1c01, q); // distinct ports
    repeat (8) @(posedge clk_i);
    chk({tx_out.clk, tx_out.data}, {28'h0000001, 28'h8000101});
    wb(1, IDX_INS_SEL, 16'h001d, q);
    repeat (8) @(posedge clk_i);
    chk({tx_out.clk, tx_out.data}, {28'h0, 28'h0000100});
    // reset in mid-run clears the selectors again
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, IDX_INS_SEL, 16'h0, q);
    chk(q, 0);
    report_and_stop();
  end
endmodule : t2_loopback_cmd_drop_insert_tb
